// file: design/motor_status_regs.vh
// register offsets, field positions and frame layout of the status bank
`ifndef MOTOR_STATUS_REGS_VH
`define MOTOR_STATUS_REGS_VH

`define ADDR_FAULT_FLAGS 7'h00
`define ADDR_DIE_TEMPERATURE 7'h01
`define ADDR_SUPPLY_MONITOR 7'h02
`define ADDR_FAULT_CLEAR 7'h10

`define RESET_FAULT_FLAGS 16'h0000
`define RESET_DIE_TEMPERATURE 16'h0000
`define RESET_SUPPLY_MONITOR 16'h0000

`define FAULT_USED_BITS 13
`define FAULT_CHARGE_PUMP 3
`define FAULT_LOCKED_ROTOR 10
`define CLEAR_FAULTS_BIT 0
`define TEMP_CODE_BITS 7
`define SUPPLY_CODE_LSB 6

`define FRAME_HEAD_BITS 5'h08
`define FRAME_BITS 5'h18

`endif

// file: design/motor_driver_status_regs.v
// status register bank of the gate driver behind the serial register port
//
// Function
// R1: read-only registers ignore host writes, value and behaviour unchanged.
// R2: write-only fault clear register always reads back as zero.
// R3: fault flags set on event, cleared only by the clear-faults bit.
// R4: fault bits 2:0 flag sense amplifier overcurrent for phases A, B, C.
// R5: fault bit 3 is set when either charge pump fails.
// R6: bits 4..7: regulator overcurrent, under-, overvoltage, buck overcurrent.
// R7: bit 8 flags over-temperature shutdown, bit 9 over-temperature warning.
// R8: bit 10 flags a locked rotor seen by Hall based detection.
// R9: bit 11 flags watchdog fault, bit 12 memory fault.
// R10: unused upper bits of all three status registers read zero.
// R11: temperature register holds a 7-bit code, 2 degC steps from -94.
// R12: supply bits 0 and 1 show low and high side pump above minimum.
// R13: supply bits 2..5 show regulator and boot supply comparators.
// R14: supply bits 12:6 hold the latest input supply conversion.
// R15: writing one to the clear-faults bit at 0x10 clears latched faults.
// R16: live fields follow present inputs; all three registers reset zero.
`timescale 1ns/1ps
`default_nettype none
`include "motor_status_regs.vh"

module motor_driver_status_regs (
    input wire sys_clk,
    input wire srst,
    input wire sclk,
    input wire cs_n,
    input wire sdi,
    output reg sdo,
    output reg sdo_oe_n,
    input wire [2:0] sense_amp_overcurrent,
    input wire lowside_pump_fault,
    input wire highside_pump_fault,
    input wire regulator_overcurrent,
    input wire regulator_undervoltage,
    input wire regulator_overvoltage,
    input wire buck_overcurrent,
    input wire overtemp_shutdown,
    input wire overtemp_warning,
    input wire locked_rotor_fault,
    input wire watchdog_fault,
    input wire nvm_fault,
    input wire [6:0] temperature_code,
    input wire lowside_pump_above_min,
    input wire highside_pump_above_min,
    input wire regulator_above_min,
    input wire regulator_above_max,
    input wire boot_supply_above_min,
    input wire boot_supply_above_max,
    input wire [6:0] input_supply_code
);

    // all pins arrive asynchronously: two flops before any logic reads them
    localparam ASYNC_W = 37;
    localparam SYNC_SCLK = 36;
    localparam SYNC_CS_N = 35;
    localparam SYNC_SDI = 34;
    // deselected idle pattern, so no false frame start follows reset
    localparam [ASYNC_W-1:0] ASYNC_IDLE = 37'h8_0000_0000;
    wire [ASYNC_W-1:0] async_in;
    reg [ASYNC_W-1:0] meta;
    reg [ASYNC_W-1:0] sync;
    reg sclk_d;

    assign async_in = {sclk,
                       cs_n,
                       sdi,
                       input_supply_code,
                       boot_supply_above_max,
                       boot_supply_above_min,
                       regulator_above_max,
                       regulator_above_min,
                       highside_pump_above_min,
                       lowside_pump_above_min,
                       temperature_code,
                       nvm_fault,
                       watchdog_fault,
                       locked_rotor_fault,
                       overtemp_warning,
                       overtemp_shutdown,
                       buck_overcurrent,
                       regulator_overvoltage,
                       regulator_undervoltage,
                       regulator_overcurrent,
                       highside_pump_fault,
                       lowside_pump_fault,
                       sense_amp_overcurrent};

    always @(posedge sys_clk) begin
        if (srst) begin
            meta <= ASYNC_IDLE;
            sync <= ASYNC_IDLE;
            sclk_d <= 1'b0;
        end else begin
            meta <= async_in;
            sync <= meta;
            sclk_d <= sync[SYNC_SCLK];
        end
    end

    wire s_sclk = sync[SYNC_SCLK];
    wire s_cs_n = sync[SYNC_CS_N];
    wire s_sdi = sync[SYNC_SDI];
    wire [6:0] s_supply_code = sync[33:27];
    wire [5:0] s_supply_cmp = sync[26:21];
    wire [6:0] s_temp_code = sync[20:14];
    wire sclk_rise = s_sclk & ~sclk_d;
    wire sclk_fall = ~s_sclk & sclk_d;

    // event bits of the sync vector mapped onto fault flag positions
    wire [12:0] event_bits;
    assign event_bits[2:0] = sync[2:0];                   // [R4]
    // either pump failing raises the one combined flag
    assign event_bits[3] = sync[3] | sync[4];             // [R5]
    assign event_bits[7:4] = sync[8:5];                   // [R6]
    assign event_bits[9:8] = sync[10:9];                  // [R7]
    assign event_bits[10] = sync[11];                     // [R8]
    assign event_bits[12:11] = sync[13:12];               // [R9]

    reg [`FAULT_USED_BITS-1:0] fault_flags;
    reg [`TEMP_CODE_BITS-1:0] die_temperature;
    reg [5:0] supply_cmp;
    reg [6:0] supply_code;

    // serial frame: write flag, 7 address bits, 16 data bits, msb first
    reg [4:0] bit_cnt;
    reg [15:0] shift_in;
    reg [15:0] shift_out;
    reg [6:0] frame_addr;
    reg frame_write;
    reg clear_req;

    // unmapped addresses and the write-only clear register read as zero
    function [15:0] read_word;
        input [6:0] addr;
        begin
            case (addr)
                `ADDR_FAULT_FLAGS:
                    read_word = {3'h0, fault_flags};          // [R10]
                `ADDR_DIE_TEMPERATURE:
                    read_word = {9'h000, die_temperature};    // [R10] [R11]
                `ADDR_SUPPLY_MONITOR:
                    read_word = {3'h0, supply_code, supply_cmp}; // [R10] [R14]
                default:
                    read_word = 16'h0000;   // clear register reads 0 [R2]
            endcase
        end
    endfunction

    wire [15:0] next_shift_in = {shift_in[14:0], s_sdi};
    // last data bit of a write frame aimed at the clear register
    wire clear_hit = bit_cnt == `FRAME_BITS - 5'h01 && frame_write &&
                     frame_addr == `ADDR_FAULT_CLEAR &&
                     next_shift_in[`CLEAR_FAULTS_BIT];

    always @(posedge sys_clk) begin
        if (srst) begin
            bit_cnt <= 5'h00;
            shift_in <= 16'h0000;
            shift_out <= 16'h0000;
            frame_addr <= 7'h00;
            frame_write <= 1'b0;
            clear_req <= 1'b0;
            sdo <= 1'b0;
            sdo_oe_n <= 1'b1;
        end else begin
            clear_req <= 1'b0;
            sdo_oe_n <= s_cs_n;
            if (s_cs_n) begin
                bit_cnt <= 5'h00;
                sdo <= 1'b0;
            end else if (sclk_rise && bit_cnt != `FRAME_BITS) begin
                shift_in <= next_shift_in;
                bit_cnt <= bit_cnt + 5'h01;
                if (bit_cnt == `FRAME_HEAD_BITS - 5'h01) begin
                    frame_write <= next_shift_in[7];
                    frame_addr <= next_shift_in[6:0];
                    // snapshot taken once so a word reads coherently
                    shift_out <= read_word(next_shift_in[6:0]);
                end
                // only the clear register acts on writes [R1]
                if (clear_hit) begin
                    clear_req <= 1'b1;                        // [R15]
                end
            end else if (sclk_fall && bit_cnt >= `FRAME_HEAD_BITS) begin
                sdo <= shift_out[15];
                shift_out <= {shift_out[14:0], 1'b0};
            end
        end
    end

    localparam [15:0] FAULT_RESET = `RESET_FAULT_FLAGS;
    localparam [15:0] TEMP_RESET = `RESET_DIE_TEMPERATURE;
    localparam [15:0] SUPPLY_RESET = `RESET_SUPPLY_MONITOR;

    // an event in the clear cycle survives the clear [R3]
    wire [12:0] next_fault_flags = (clear_req ? 13'h0 : fault_flags) |
                                   event_bits;

    always @(posedge sys_clk) begin
        if (srst) begin
            fault_flags <= FAULT_RESET[12:0];                 // [R16]
        end else begin
            fault_flags <= next_fault_flags;                  // [R3]
        end
    end

    // live fields follow the inputs one clock behind the two-flop synchroniser
    always @(posedge sys_clk) begin
        if (srst) begin
            die_temperature <= TEMP_RESET[6:0];               // [R16]
            supply_cmp <= SUPPLY_RESET[5:0];
            supply_code <= SUPPLY_RESET[12:6];
        end else begin
            die_temperature <= s_temp_code;                   // [R11] [R16]
            supply_cmp <= s_supply_cmp;                       // [R12] [R13]
            supply_code <= s_supply_code;                     // [R14]
        end
    end

endmodule // motor_driver_status_regs
`default_nettype wire

// file: verif/motor_driver_status_regs_assertions.sv
// assertions on serial port reset, idle and shift timing
`timescale 1ns/1ps
`default_nettype none
module status_port_checker (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdo,
    input wire logic sdo_oe_n
);
default clocking @(posedge sys_clk); endclocking
default disable iff (srst);
sequence s_idle; cs_n [*4]; endsequence
sequence s_sel; !cs_n [*4]; endsequence
property p_rst; disable iff (1'b0) srst |=> sdo_oe_n && !sdo; endproperty
a_rst: assert property (p_rst) else $error("port live in reset");
property p_idle_sdo; s_idle |=> !sdo; endproperty
a_idle_sdo: assert property (p_idle_sdo) else $error("sdo idle");
property p_idle_oe; s_idle |=> sdo_oe_n; endproperty
a_idle_oe: assert property (p_idle_oe) else $error("oe idle");
property p_sel_oe; s_sel |=> !sdo_oe_n; endproperty
a_sel_oe: assert property (p_sel_oe) else $error("oe sel");
property p_hdr; $fell(cs_n) |-> !sdo [*8]; endproperty
a_hdr: assert property (p_hdr) else $error("sdo in header");
// read bits may only move while sclk is low after a falling edge
property p_shift;
    !cs_n && $past(cs_n, 8) == 1'b0 && $changed(sdo) |-> !$past(sclk, 2);
endproperty
a_shift: assert property (p_shift) else $error("sdo moved");
property p_oe_up; $rose(sdo_oe_n) |-> cs_n; endproperty
a_oe_up: assert property (p_oe_up) else $error("oe up");
property p_oe_dn; $fell(sdo_oe_n) |-> !cs_n; endproperty
a_oe_dn: assert property (p_oe_dn) else $error("oe down");
endmodule // status_port_checker
bind motor_driver_status_regs status_port_checker i_chk (.sys_clk, .srst,
    .sclk, .cs_n, .sdo, .sdo_oe_n);
`default_nettype wire

// file: verif/serial_host_model.sv
// host side of the serial register port, mode 0, msb first
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
    input wire logic sys_clk,
    input wire logic sdo,
    input wire logic sdo_oe_n,
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
initial {sclk, cs_n, sdi} = 3'b010;
// read bits are taken late in the high phase, well clear of the shift lag
task automatic xfer(input logic wr, input logic [6:0] adr,
        input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] fr;
    fr = {wr, adr, wd};
    @(negedge sys_clk) cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
        sdi = fr[i];
        repeat (4) @(negedge sys_clk);
        sclk = 1'b1;
        repeat (4) @(negedge sys_clk);
        // a released line reads inverted, so a late enable shows up
        if (i < 16) rd[i] = sdo_oe_n ? ~sdo : sdo;
        sclk = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    cs_n = 1'b1;
    sdi = ~sdi;
    repeat (6) @(negedge sys_clk);
endtask
endmodule // serial_host_model
`default_nettype wire

// file: verif/motor_driver_status_regs_tb_top.sv
// bench of the status bank, all traffic through the serial host model
`timescale 1ns/1ps
`default_nettype none
module motor_driver_status_regs_tb_top;
logic sys_clk, srst, sdo, sdo_oe_n, sclk, cs_n, sdi;
logic [13:0] ev;
logic [6:0] tc, vc;
logic [5:0] fl;
logic [15:0] rdata;
int error_cnt = 0;
int checks_done = 0;
motor_driver_status_regs i_dut (.sys_clk, .srst, .sclk, .cs_n, .sdi, .sdo,
    .sdo_oe_n, .sense_amp_overcurrent(ev[2:0]), .lowside_pump_fault(ev[3]),
    .highside_pump_fault(ev[13]), .regulator_overcurrent(ev[4]),
    .regulator_undervoltage(ev[5]), .regulator_overvoltage(ev[6]),
    .buck_overcurrent(ev[7]), .overtemp_shutdown(ev[8]),
    .overtemp_warning(ev[9]), .locked_rotor_fault(ev[10]),
    .watchdog_fault(ev[11]), .nvm_fault(ev[12]), .temperature_code(tc),
    .lowside_pump_above_min(fl[0]), .highside_pump_above_min(fl[1]),
    .regulator_above_min(fl[2]), .regulator_above_max(fl[3]),
    .boot_supply_above_min(fl[4]), .boot_supply_above_max(fl[5]),
    .input_supply_code(vc));
serial_host_model i_host (.sys_clk, .sdo, .sdo_oe_n, .sclk, .cs_n, .sdi);
task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
        error_cnt++;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    i_host.xfer(1'b0, a, 16'h0000, rdata);
    check(rdata, exp);
endtask
task automatic tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
end
initial begin
    {srst, ev, tc, vc, fl} = {1'b1, 34'h0};
    repeat (16) @(negedge sys_clk);
    srst = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int a = 0; a < 3; a++) rd(a[6:0], 16'h0000);
    rd(7'h10, 16'h0000);
    rd(7'h05, 16'h0000);
    {tc, vc, fl} = {7'h7F, 7'h55, 6'h3F};
    i_host.xfer(1'b1, 7'h01, 16'hFFFF, rdata);
    i_host.xfer(1'b1, 7'h02, 16'h0000, rdata);
    rd(7'h01, 16'h007F);
    rd(7'h02, 16'h157F);
    {tc, vc, fl} = {7'h2A, 7'h2A, 6'h15};
    rd(7'h01, 16'h002A);
    rd(7'h02, 16'h0A95);
    // entry 13 is the high side pump, which shares bit 3
    for (int k = 0; k < 14; k++) begin
        ev[k] = 1'b1;
        repeat (3) @(negedge sys_clk);
        ev[k] = 1'b0;
        rd(7'h00, 16'h0001 << (k == 13 ? 3 : k));
        i_host.xfer(1'b1, 7'h00, 16'hFFFF, rdata);
        i_host.xfer(1'b1, 7'h10, 16'hFFFE, rdata);
        rd(7'h00, 16'h0001 << (k == 13 ? 3 : k));
        i_host.xfer(1'b1, 7'h10, 16'h0001, rdata);
        rd(7'h00, 16'h0000);
    end
    rd(7'h10, 16'h0000);
    tally_and_finish;
end
endmodule // motor_driver_status_regs_tb_top
`default_nettype wire
